/* File: hw/port_func_pkg.sv */
// constants, register map and carrier types for the port function block
// assumes an 8-bit register port with 16-bit byte addresses
package port_func_pkg;

    // register byte addresses
    localparam logic [15:0] TWO_DIR_ADDR      = 16'hFF81;
    localparam logic [15:0] TWO_LATCH_ADDR    = 16'hFF83;
    localparam logic [15:0] THREE_DIR_ADDR    = 16'hFF84;
    localparam logic [15:0] THREE_LATCH_ADDR  = 16'hFF86;

    // reset values and fixed read patterns
    localparam logic [7:0]  TWO_DIR_RESET     = 8'hE0;
    localparam logic [7:0]  TWO_LATCH_RESET   = 8'hE0;
    localparam logic [7:0]  THREE_DIR_RESET   = 8'h00;
    localparam logic [7:0]  THREE_LATCH_RESET = 8'h00;
    localparam logic [7:0]  TWO_FIXED_ONES    = 8'hE0;
    localparam logic [7:0]  DIR_READ_VALUE    = 8'hFF;
    localparam logic [7:0]  UNMAPPED_READ     = 8'h00;
    localparam logic [7:0]  ALL_OUT           = 8'hFF;
    localparam logic [7:0]  ALL_IN            = 8'h00;

    // port widths
    localparam int          TWO_WIDTH         = 5;
    localparam int          BYTE_WIDTH        = 8;
    localparam int          SYNC_WIDTH        = 21;

    // first port pin positions
    localparam int          TOP_PIN           = 7;
    localparam int          SECOND_IRQ_PIN    = 6;
    localparam int          FIRST_IRQ_PIN     = 5;
    localparam int          ENABLE_CLOCK_PIN  = 1;
    localparam int          SYSTEM_CLOCK_PIN  = 0;

    // operating mode codes
    localparam logic [2:0]  MODE_SINGLE_CHIP  = 3'h7;
    localparam logic [2:0]  MODE_EXP_LOW      = 3'h1;
    localparam logic [2:0]  MODE_EXP_HIGH     = 3'h4;

    // level and enable of one port's pins
    typedef struct packed {
        logic [7:0] level;
        logic [7:0] enable;
    } pin_drive_s;

    // expanded modes are codes one to four
    function automatic logic is_expanded(input logic [2:0] mode);
        return (mode >= MODE_EXP_LOW) && (mode <= MODE_EXP_HIGH);
    endfunction

endpackage

/* File: hw/pin_sync.sv */
// three-stage synchroniser for asynchronous pin levels
// assumes one clock domain; output follows once stages two and three agree
`timescale 1ns/100ps
`default_nettype none
module pin_sync
    import port_func_pkg::*;
#(
    parameter int WIDTH = SYNC_WIDTH
) (
    // clock and reset
    input  wire logic             clk_in,
    input  wire logic             rstn_in,
    // levels
    input  wire logic [WIDTH-1:0] async_in,
    output var  logic [WIDTH-1:0] stable_out
);

    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;
    logic [WIDTH-1:0] stage3_reg;

    // shift chain; stage one feeds only stage two
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            stage1_reg <= '0;
            stage2_reg <= '0;
            stage3_reg <= '0;
        end else begin
            stage1_reg <= async_in;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
        end
    end

    // accept a bit once two and three agree
    generate
        for (genvar i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge clk_in or negedge rstn_in) begin
                if (!rstn_in) begin
                    stable_out[i] <= 1'b0;
                end else if (stage2_reg[i] == stage3_reg[i]) begin
                    stable_out[i] <= stage3_reg[i];
                end
            end
        end
    endgenerate

endmodule // pin_sync
`default_nettype wire

/* File: hw/port_function.sv */
// pin function selection for the first port, plus the five-bit and
// eight-bit general ports with their direction and data registers
// assumes mode pins are steady around reset release and that the timer,
// interrupt control and first-port registers live in other blocks
//
// How it works
// - any timer select bit set makes top pin drive timer output, else GPIO
// - second irq enable makes bit 6 an interrupt input, else GPIO
// - first irq enable makes bit 5 an interrupt input, else GPIO
// - bits 4 to 2 of first port are plain GPIO by direction bit
// - bit 1 is input, or drives the enable clock when direction is one
// - bit 0 is input, or drives the system clock when direction is one
// - expanded modes: five-bit port drives the bus control strobes
// - expanded modes: five-bit direction forced to ones, writes ignored
// - single-chip: five-bit pin direction follows its direction bit
// - five-bit direction is writable but always reads all ones
// - upper three bits of five-bit port registers read one, ignore writes
// - reset and hardware standby clear five-bit direction, making the pins inputs in single-chip mode
// - software standby keeps five-bit direction and output drive
// - five-bit data read gives latch for outputs, pin for inputs
// - expanded modes: eight-bit port is the data bus, direction steers only data readback
// - single-chip: eight-bit pin direction follows its direction bit
// - eight-bit direction is writable but always reads all ones
// - reset and hardware standby clear eight-bit direction and data
// - software standby keeps eight-bit direction and output drive
// - eight-bit data read gives latch for outputs, pin for inputs
// - clock pins set as outputs read back the current clock levels
//
// Implementation choice: strobed register access.
`timescale 1ns/100ps
`default_nettype none
module port_function
    import port_func_pkg::*;
(
    // clock and reset
    input  wire logic             CLK_IN,
    input  wire logic             RSTN_IN,
    // operating state
    input  wire logic [2:0]       MODE_IN,
    input  wire logic             HW_STANDBY_IN,
    input  wire logic             SW_STANDBY_IN,
    // register port
    input  wire logic [15:0]      ADDR_IN,
    input  wire logic [7:0]       WDATA_IN,
    input  wire logic             WR_IN,
    input  wire logic             RD_IN,
    output var  logic [7:0]       RDATA_OUT,
    // first port controls from neighbouring blocks
    input  wire logic [7:0]       P1_DIR_IN,
    input  wire logic [7:0]       P1_LATCH_IN,
    input  wire logic [3:0]       TIMER_OUTPUT_SELECT_IN,
    input  wire logic             TIMER_OUTPUT_SIGNAL_IN,
    input  wire logic             FIRST_IRQ_ENABLE_IN,
    input  wire logic             SECOND_IRQ_ENABLE_IN,
    input  wire logic             ENABLE_CLOCK_IN,
    input  wire logic             SYSTEM_CLOCK_IN,
    // first port pins and derived signals
    input  wire logic [7:0]       P1_PIN_IN,
    output var  pin_drive_s       P1_DRIVE_OUT,
    output var  logic [7:0]       P1_READ_OUT,
    output var  logic             FIRST_EXTERNAL_INTERRUPT_OUT,
    output var  logic             SECOND_EXTERNAL_INTERRUPT_OUT,
    // five-bit port pins and bus strobes
    input  wire logic [4:0]       P2_PIN_IN,
    input  wire logic [4:0]       BUS_STROBE_IN,
    output var  pin_drive_s       P2_DRIVE_OUT,
    // eight-bit port pins and external data bus
    input  wire logic [7:0]       P3_PIN_IN,
    input  wire logic [7:0]       EXT_DATA_IN,
    input  wire logic             EXT_DATA_OE_IN,
    output var  pin_drive_s       P3_DRIVE_OUT,
    output var  logic [7:0]       EXT_DATA_OUT
);

    logic [TWO_WIDTH-1:0]  two_dir_reg;
    logic [TWO_WIDTH-1:0]  two_latch_reg;
    logic [7:0]            three_dir_reg;
    logic [7:0]            three_latch_reg;
    logic                  expanded_reg;
    logic                  strap_done_reg;
    logic [SYNC_WIDTH-1:0] pins_sync;
    logic [7:0]            p1_sync;
    logic [7:0]            p2_sync;
    logic [7:0]            p3_sync;
    logic [7:0]            two_dir_eff;
    logic [7:0]            two_latch_full;
    logic [7:0]            p1_dir_eff;
    logic                  wr_two_dir;
    logic                  wr_two_latch;
    logic                  wr_three_dir;
    logic                  wr_three_latch;
    logic                  timer_selected;
    pin_drive_s            p1_next;
    pin_drive_s            p2_next;
    pin_drive_s            p3_next;
    logic [7:0]            rdata_next;
    logic [7:0]            p1_read_next;

    // address match for one strobe
    function automatic logic hit(input logic strobe, input logic [15:0] a,
                                 input logic [15:0] target);
        return strobe && (a == target);
    endfunction

    // latch for outputs, live pin for inputs
    function automatic logic [7:0] mix_read(input logic [7:0] dir,
                                            input logic [7:0] latch,
                                            input logic [7:0] pin);
        return (dir & latch) | (~dir & pin);
    endfunction

    // pin levels enter through the synchroniser
    pin_sync #(
        .WIDTH      (SYNC_WIDTH)
    ) u_pin_sync (
        .clk_in     (CLK_IN),
        .rstn_in    (RSTN_IN),
        .async_in   ({P3_PIN_IN, P2_PIN_IN, P1_PIN_IN}),
        .stable_out (pins_sync)
    );

    // split synchronised levels per port
    assign p1_sync = pins_sync[7:0];
    assign p2_sync = {3'b000, pins_sync[12:8]};
    assign p3_sync = pins_sync[20:13];

    // mode strap caught once after reset release
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            strap_done_reg <= 1'b0;
            expanded_reg   <= 1'b0;
        end else if (!strap_done_reg) begin
            strap_done_reg <= 1'b1;
            expanded_reg   <= is_expanded(MODE_IN);
        end
    end

    // write decode
    assign wr_two_dir     = hit(WR_IN, ADDR_IN, TWO_DIR_ADDR);
    assign wr_two_latch   = hit(WR_IN, ADDR_IN, TWO_LATCH_ADDR);
    assign wr_three_dir   = hit(WR_IN, ADDR_IN, THREE_DIR_ADDR);
    assign wr_three_latch = hit(WR_IN, ADDR_IN, THREE_LATCH_ADDR);

    // five-bit direction; software standby has no effect here
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            two_dir_reg <= TWO_DIR_RESET[4:0];
        end else if (HW_STANDBY_IN) begin
            two_dir_reg <= TWO_DIR_RESET[4:0];
        end else if (wr_two_dir && !expanded_reg) begin
            two_dir_reg <= WDATA_IN[4:0];
        end
    end

    // five-bit data latch, written whatever the direction
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            two_latch_reg <= TWO_LATCH_RESET[4:0];
        end else if (HW_STANDBY_IN) begin
            two_latch_reg <= TWO_LATCH_RESET[4:0];
        end else if (wr_two_latch) begin
            two_latch_reg <= WDATA_IN[4:0];
        end
    end

    // eight-bit direction, kept in expanded modes where it steers only data readback
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            three_dir_reg <= THREE_DIR_RESET;
        end else if (HW_STANDBY_IN) begin
            three_dir_reg <= THREE_DIR_RESET;
        end else if (wr_three_dir) begin
            three_dir_reg <= WDATA_IN;
        end
    end

    // eight-bit data latch
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            three_latch_reg <= THREE_LATCH_RESET;
        end else if (HW_STANDBY_IN) begin
            three_latch_reg <= THREE_LATCH_RESET;
        end else if (wr_three_latch) begin
            three_latch_reg <= WDATA_IN;
        end
    end

    // effective directions and padded latch
    assign two_dir_eff    = expanded_reg ? ALL_OUT
                                         : {3'b000, two_dir_reg};
    assign two_latch_full = {3'b000, two_latch_reg};
    assign timer_selected = |TIMER_OUTPUT_SELECT_IN;

    // first port direction as seen by readback
    always_comb begin
        p1_dir_eff = P1_DIR_IN;
        if (SECOND_IRQ_ENABLE_IN) begin
            p1_dir_eff[SECOND_IRQ_PIN] = 1'b0;
        end
        if (FIRST_IRQ_ENABLE_IN) begin
            p1_dir_eff[FIRST_IRQ_PIN] = 1'b0;
        end
    end

    // first port pin functions
    always_comb begin
        p1_next.level  = P1_LATCH_IN;
        p1_next.enable = p1_dir_eff;
        if (timer_selected) begin
            p1_next.level[TOP_PIN]  = TIMER_OUTPUT_SIGNAL_IN;
            p1_next.enable[TOP_PIN] = 1'b1;
        end
        p1_next.level[ENABLE_CLOCK_PIN] = ENABLE_CLOCK_IN;
        p1_next.level[SYSTEM_CLOCK_PIN] = SYSTEM_CLOCK_IN;
    end

    // five-bit port: strobes when expanded, latch otherwise
    always_comb begin
        if (expanded_reg) begin
            p2_next.level  = {3'b000, BUS_STROBE_IN};
            p2_next.enable = {3'b000, ALL_OUT[4:0]};
        end else begin
            p2_next.level  = two_latch_full;
            p2_next.enable = two_dir_eff;
        end
    end

    // eight-bit port: data bus when expanded, latch otherwise
    always_comb begin
        if (expanded_reg) begin
            p3_next.level  = EXT_DATA_IN;
            p3_next.enable = EXT_DATA_OE_IN ? ALL_OUT : ALL_IN;
        end else begin
            p3_next.level  = three_latch_reg;
            p3_next.enable = three_dir_reg;
        end
    end

    // pin drivers from flip-flops
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            P1_DRIVE_OUT <= '0;
            P2_DRIVE_OUT <= '0;
            P3_DRIVE_OUT <= '0;
        end else begin
            P1_DRIVE_OUT <= p1_next;
            P2_DRIVE_OUT <= p2_next;
            P3_DRIVE_OUT <= p3_next;
        end
    end

    // first port readback; clock pins set as outputs show the clock itself
    always_comb begin
        p1_read_next = mix_read(p1_dir_eff, P1_LATCH_IN, p1_sync);
        if (P1_DIR_IN[ENABLE_CLOCK_PIN]) begin
            p1_read_next[ENABLE_CLOCK_PIN] = ENABLE_CLOCK_IN;
        end
        if (P1_DIR_IN[SYSTEM_CLOCK_PIN]) begin
            p1_read_next[SYSTEM_CLOCK_PIN] = SYSTEM_CLOCK_IN;
        end
    end

    // interrupt inputs, bus data and first port readback
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            P1_READ_OUT                   <= '0;
            EXT_DATA_OUT                  <= '0;
            FIRST_EXTERNAL_INTERRUPT_OUT  <= 1'b0;
            SECOND_EXTERNAL_INTERRUPT_OUT <= 1'b0;
        end else begin
            P1_READ_OUT  <= p1_read_next;
            EXT_DATA_OUT <= p3_sync;
            FIRST_EXTERNAL_INTERRUPT_OUT  <=
                FIRST_IRQ_ENABLE_IN & p1_sync[FIRST_IRQ_PIN];
            SECOND_EXTERNAL_INTERRUPT_OUT <=
                SECOND_IRQ_ENABLE_IN & p1_sync[SECOND_IRQ_PIN];
        end
    end

    // register read mux
    always_comb begin
        rdata_next = UNMAPPED_READ;
        if (hit(RD_IN, ADDR_IN, TWO_DIR_ADDR)) begin
            rdata_next = DIR_READ_VALUE;
        end else if (hit(RD_IN, ADDR_IN, TWO_LATCH_ADDR)) begin
            rdata_next = TWO_FIXED_ONES |
                mix_read(two_dir_eff, two_latch_full, p2_sync);
        end else if (hit(RD_IN, ADDR_IN, THREE_DIR_ADDR)) begin
            rdata_next = DIR_READ_VALUE;
        end else if (hit(RD_IN, ADDR_IN, THREE_LATCH_ADDR)) begin
            rdata_next = mix_read(three_dir_reg, three_latch_reg,
                                  p3_sync);
        end
    end

    // read data stands one cycle after the strobe
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            RDATA_OUT <= UNMAPPED_READ;
        end else begin
            RDATA_OUT <= rdata_next;
        end
    end

    // checks on readback
    property p_two_dir_ones;
        @(posedge CLK_IN) disable iff (!RSTN_IN)
        hit(RD_IN, ADDR_IN, TWO_DIR_ADDR) |=> RDATA_OUT == 8'hFF;
    endproperty
    a_two_dir_ones: assert property (p_two_dir_ones)
        else $error("five-bit direction read not all ones");

    property p_three_dir_ones;
        @(posedge CLK_IN) disable iff (!RSTN_IN)
        hit(RD_IN, ADDR_IN, THREE_DIR_ADDR) |=> RDATA_OUT == 8'hFF;
    endproperty
    a_three_dir_ones: assert property (p_three_dir_ones)
        else $error("eight-bit direction read not all ones");

    property p_two_reserved;
        @(posedge CLK_IN) disable iff (!RSTN_IN)
        hit(RD_IN, ADDR_IN, TWO_LATCH_ADDR) |=> RDATA_OUT[7:5] == 3'b111;
    endproperty
    a_two_reserved: assert property (p_two_reserved)
        else $error("five-bit data upper bits not one");

    property p_three_mix;
        @(posedge CLK_IN) disable iff (!RSTN_IN)
        hit(RD_IN, ADDR_IN, THREE_LATCH_ADDR) && !wr_three_latch
        |=> RDATA_OUT == (($past(three_dir_reg) & $past(three_latch_reg))
                       | (~$past(three_dir_reg) & $past(p3_sync)));
    endproperty
    a_three_mix: assert property (p_three_mix)
        else $error("eight-bit data read mix wrong");

    // checks on pin drive, register updates and clock pin readback
    property p_two_strobes;
        @(posedge CLK_IN) disable iff (!RSTN_IN)
        expanded_reg |=> P2_DRIVE_OUT.enable == 8'h1F
                      && P2_DRIVE_OUT.level[4:0] == $past(BUS_STROBE_IN);
    endproperty
    a_two_strobes: assert property (p_two_strobes)
        else $error("expanded mode strobes not driven");

    property p_three_bus;
        @(posedge CLK_IN) disable iff (!RSTN_IN)
        expanded_reg && EXT_DATA_OE_IN
        |=> P3_DRIVE_OUT.enable == 8'hFF
         && P3_DRIVE_OUT.level == $past(EXT_DATA_IN);
    endproperty
    a_three_bus: assert property (p_three_bus)
        else $error("expanded data bus not driven");

    property p_two_single_dir;
        @(posedge CLK_IN) disable iff (!RSTN_IN)
        !expanded_reg ##1 !expanded_reg
        |-> P2_DRIVE_OUT.enable[4:0] == $past(two_dir_reg);
    endproperty
    a_two_single_dir: assert property (p_two_single_dir)
        else $error("five-bit enable does not follow direction");

    property p_two_locked;
        @(posedge CLK_IN) disable iff (!RSTN_IN)
        expanded_reg && wr_two_dir && !HW_STANDBY_IN |=> $stable(two_dir_reg);
    endproperty
    a_two_locked: assert property (p_two_locked)
        else $error("five-bit direction changed in expanded mode");

    property p_standby_init;
        @(posedge CLK_IN) disable iff (!RSTN_IN)
        HW_STANDBY_IN |=> two_dir_reg == 5'h00 && three_dir_reg == 8'h00
                       && three_latch_reg == 8'h00;
    endproperty
    a_standby_init: assert property (p_standby_init)
        else $error("hardware standby did not initialise");

    property p_latch_write;
        @(posedge CLK_IN) disable iff (!RSTN_IN)
        wr_two_latch && !HW_STANDBY_IN
        |=> two_latch_reg == $past(WDATA_IN[4:0]);
    endproperty
    a_latch_write: assert property (p_latch_write)
        else $error("five-bit latch not written");

    property p_timer_pin;
        @(posedge CLK_IN) disable iff (!RSTN_IN)
        TIMER_OUTPUT_SELECT_IN != 4'h0
        |=> P1_DRIVE_OUT.enable[7] && P1_DRIVE_OUT.level[7]
            == $past(TIMER_OUTPUT_SIGNAL_IN);
    endproperty
    a_timer_pin: assert property (p_timer_pin)
        else $error("top pin not driving timer output");

    property p_irq_pin;
        @(posedge CLK_IN) disable iff (!RSTN_IN)
        FIRST_IRQ_ENABLE_IN |=> !P1_DRIVE_OUT.enable[5];
    endproperty
    a_irq_pin: assert property (p_irq_pin)
        else $error("interrupt pin still driven");

    property p_clock_read;
        @(posedge CLK_IN) disable iff (!RSTN_IN)
        P1_DIR_IN[0] |=> P1_READ_OUT[0] == $past(SYSTEM_CLOCK_IN);
    endproperty
    a_clock_read: assert property (p_clock_read)
        else $error("clock pin readback wrong");

    // software standby alone never disturbs the direction registers
    property p_sw_keep;
        @(posedge CLK_IN) disable iff (!RSTN_IN)
        SW_STANDBY_IN && !WR_IN && !HW_STANDBY_IN
        |=> $stable(two_dir_reg) && $stable(three_dir_reg);
    endproperty
    a_sw_keep: assert property (p_sw_keep)
        else $error("software standby changed a direction register");

endmodule // port_function
`default_nettype wire

/* File: testbench/pin_model.sv */
// outside world of one port: resolves each pin from design drive
// assumes bits the design does not drive show the level set by the bench
`timescale 1ns/100ps
`default_nettype none
module pin_model
    import port_func_pkg::*;
#(
    parameter int W = 8
) (
    // design drive and outside level
    input  wire pin_drive_s   drive_in,
    input  wire logic [W-1:0] ext_in,
    // resolved pin level
    output var  logic [W-1:0] pin_out
);
    // driven bits show the design level, others the outside level
    always_comb pin_out = (drive_in.level[W-1:0] & drive_in.enable[W-1:0])
                        | (ext_in & ~drive_in.enable[W-1:0]);
endmodule // pin_model
`default_nettype wire

/* File: testbench/testbench.sv */
// self-checking bench for the port function block
// assumes pin sync settles within 8 cycles and drives lag one cycle
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin \
    err_count++; $display("wrong value %s exp %h got %h", nm, e, g); end end
module testbench;
    import port_func_pkg::*;
    logic clk = 0, rstn = 0, hws = 0, sws = 0, wr = 0, rd = 0;
    logic [2:0] mode = MODE_SINGLE_CHIP;
    logic [15:0] addr = 16'h0000;
    logic [7:0] wd = 8'h00, rdat, p1dir = 8'h00, p1lat = 8'h00;
    logic [7:0] e1 = 8'h00, e3 = 8'h00, xd = 8'h00, p1, p3, rdata, p1rd, xo;
    logic [4:0] e2 = 5'h00, strb = 5'h00, p2;
    logic [3:0] tsel = 4'h0;
    logic tsig = 0, first_external_interrupt = 0, second_external_interrupt = 0, eclk = 0, sclk = 0, xoe = 0, i0, i1;
    pin_drive_s d1, d2, d3;
    int err_count = 0, total_checks = 0;
    // clock and watchdog
    initial forever #2.5 clk = ~clk;
    initial begin #200000; err_count++; print_verdict(); end
    port_function port_function_i (.CLK_IN(clk), .RSTN_IN(rstn),
        .MODE_IN(mode), .HW_STANDBY_IN(hws), .SW_STANDBY_IN(sws),
        .ADDR_IN(addr), .WDATA_IN(wd), .WR_IN(wr), .RD_IN(rd),
        .RDATA_OUT(rdata), .P1_DIR_IN(p1dir), .P1_LATCH_IN(p1lat),
        .TIMER_OUTPUT_SELECT_IN(tsel), .TIMER_OUTPUT_SIGNAL_IN(tsig),
        .FIRST_IRQ_ENABLE_IN(first_external_interrupt), .SECOND_IRQ_ENABLE_IN(second_external_interrupt),
        .ENABLE_CLOCK_IN(eclk), .SYSTEM_CLOCK_IN(sclk), .P1_PIN_IN(p1),
        .P1_DRIVE_OUT(d1), .P1_READ_OUT(p1rd),
        .FIRST_EXTERNAL_INTERRUPT_OUT(i0), .SECOND_EXTERNAL_INTERRUPT_OUT(i1),
        .P2_PIN_IN(p2), .BUS_STROBE_IN(strb), .P2_DRIVE_OUT(d2),
        .P3_PIN_IN(p3), .EXT_DATA_IN(xd), .EXT_DATA_OE_IN(xoe),
        .P3_DRIVE_OUT(d3), .EXT_DATA_OUT(xo));
    pin_model #(.W(8)) m1 (.drive_in(d1), .ext_in(e1), .pin_out(p1));
    pin_model #(.W(5)) m2 (.drive_in(d2), .ext_in(e2), .pin_out(p2));
    pin_model #(.W(8)) m3 (.drive_in(d3), .ext_in(e3), .pin_out(p3));
    // bus cycles and waits
    task automatic cyc(input int n); repeat (n) @(posedge clk); endtask
    task automatic bw(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk); addr <= a; wd <= d; wr <= 1'b1;
        @(posedge clk); wr <= 1'b0;
    endtask
    task automatic br(input logic [15:0] a);
        @(posedge clk); addr <= a; rd <= 1'b1;
        @(posedge clk); rd <= 1'b0;
        #1 rdat = rdata;
    endtask
    task automatic do_reset(input logic [2:0] m);
        @(posedge clk); rstn <= 1'b0; mode <= m;
        cyc(2); rstn <= 1'b1; cyc(3);
    endtask
    task automatic t_reset;
        e2 <= 5'h0A; e3 <= 8'h3C; cyc(8);
        `CHK("p2 en", 8'h00, d2.enable)
        `CHK("p3 en", 8'h00, d3.enable)
        br(TWO_DIR_ADDR);    `CHK("p2 dir", 8'hFF, rdat)
        br(TWO_LATCH_ADDR);  `CHK("p2 dat", 8'hEA, rdat)
        br(THREE_DIR_ADDR);  `CHK("p3 dir", 8'hFF, rdat)
        br(THREE_LATCH_ADDR); `CHK("p3 dat", 8'h3C, rdat)
        br(16'hFFF0);        `CHK("unmapped", 8'h00, rdat)
    endtask
    task automatic t_two;
        bw(TWO_DIR_ADDR, 8'h13); bw(TWO_LATCH_ADDR, 8'h15); cyc(8);
        br(TWO_LATCH_ADDR); `CHK("p2 mix", 8'hF9, rdat)
        `CHK("p2 en", 8'h13, d2.enable)
        `CHK("p2 lvl", 8'h11, d2.level & d2.enable)
        sws <= 1'b1; cyc(4);
        `CHK("p2 sw", 8'h13, d2.enable)
        `CHK("p2 swl", 8'h11, d2.level & d2.enable)
        sws <= 1'b0; bw(TWO_DIR_ADDR, 8'h1F); cyc(2);
        `CHK("p2 late", 5'h15, d2.level[4:0])
    endtask
    task automatic t_three;
        bw(THREE_DIR_ADDR, 8'hF0); bw(THREE_LATCH_ADDR, 8'h5A);
        e3 <= 8'h33; cyc(8);
        br(THREE_LATCH_ADDR); `CHK("p3 mix", 8'h53, rdat)
        `CHK("p3 en", 8'hF0, d3.enable)
        sws <= 1'b1; cyc(4);
        `CHK("p3 sw", 8'h50, d3.level & d3.enable)
        sws <= 1'b0;
        hws <= 1'b1; cyc(2); hws <= 1'b0; cyc(8);
        br(THREE_LATCH_ADDR); `CHK("p3 hw", 8'h33, rdat)
        `CHK("p2 hw", 8'h00, d2.enable)
    endtask
    task automatic t_first;
        p1dir <= 8'h1F; p1lat <= 8'h14; eclk <= 1'b1; cyc(3);
        `CHK("p1 en", 8'h1F, d1.enable)
        `CHK("p1 gpio", 3'h5, d1.level[4:2])
        `CHK("p1 clk", 2'h2, d1.level[1:0])
        `CHK("p1 rdclk", 2'h2, p1rd[1:0])
        p1dir <= 8'hFF; tsel <= 4'h8; tsig <= 1'b1;
        first_external_interrupt <= 1'b1; second_external_interrupt <= 1'b1; e1 <= 8'h60;
        sclk <= 1'b1; eclk <= 1'b0; cyc(8);
        `CHK("p1 clk2", 2'h1, d1.level[1:0])
        `CHK("p1 rd", 8'h75, p1rd)
        `CHK("p1 tmr", 2'h3, {d1.enable[7], d1.level[7]})
        `CHK("p1 irq", 2'h0, d1.enable[6:5])
        `CHK("irq", 2'h3, {i1, i0})
    endtask
    task automatic t_expanded;
        strb <= 5'h15; xoe <= 1'b1; xd <= 8'hA5;
        do_reset(MODE_EXP_LOW); bw(TWO_DIR_ADDR, 8'h1F); cyc(2);
        `CHK("p2 exp en", 8'h1F, d2.enable)
        `CHK("p2 strobe", 5'h15, d2.level[4:0])
        `CHK("p3 bus", 16'hA5FF, {d3.level, d3.enable})
        br(TWO_LATCH_ADDR); `CHK("p2 exp dat", 8'hE0, rdat)
        xoe <= 1'b0; e3 <= 8'hC3; cyc(8);
        `CHK("p3 rel", 8'h00, d3.enable)
        `CHK("p3 in", 8'hC3, xo)
    endtask
    task automatic print_verdict;
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // main sequence
    initial begin
        cyc(2); rstn <= 1'b1; cyc(3);
        t_reset(); t_two(); t_three(); t_first(); t_expanded();
        print_verdict();
    end
endmodule // testbench
`default_nettype wire
